// ### rlc_consts.vh
// Constants for the relay control and routing matrix
`ifndef RLC_CONSTS_VH
`define RLC_CONSTS_VH

// Register byte offsets
`define RLC_ADDR_SWB1 8'h00
`define RLC_ADDR_SWB2 8'h04
`define RLC_ADDR_SWB3 8'h08
`define RLC_ADDR_BANK 8'h0C
`define RLC_ADDR_STATUS 8'h10
`define RLC_ADDR_IRQ_STAT 8'h14
`define RLC_ADDR_IRQ_MASK 8'h18
`define RLC_ADDR_DISP_SEL 8'h1C
`define RLC_ADDR_DISP_VAL 8'h20
`define RLC_ADDR_LATCH_EN 8'h24
`define RLC_ADDR_INDIC 8'h28
`define RLC_ADDR_SWR_BASE 8'h40
`define RLC_ADDR_SWR_LAST 8'h68

// Reset values
`define RLC_RST_SW 8'h00
`define RLC_RST_SEL 3'h0

// Control switchgroup bit positions (switch n sits at bit n-1)
`define RLC_SWB_BANK 4
`define RLC_SWB_BIT6 5
`define RLC_SWB_IND_LATCH 6
`define RLC_SWB_ALL 7

// Bank select command code and bank bit in the command word
`define RLC_BANK_CMD 8'h96
`define RLC_BANK_BIT 8

// Counts
`define RLC_NUM_SWR 11
`define RLC_NUM_OUT 4
`define RLC_NUM_STAGE 5
`define RLC_UNBAL_STAGE 4

// Measured value limits, in tenths of rated current; the unbalance limit is in percent
`define RLC_PHASE_MAX 10'h276
`define RLC_RESID_MAX 10'h0D2
`define RLC_PCT_MAX 10'h064

// Display selections
`define RLC_DISP_L1 3'h0
`define RLC_DISP_L2 3'h1
`define RLC_DISP_L3 3'h2
`define RLC_DISP_RES 3'h3
`define RLC_DISP_UNB 3'h4

// AXI responses
`define RLC_RESP_OKAY 2'h0
`define RLC_RESP_SLVERR 2'h2

`endif

// ### rlc_display.v
// Measured value display: clamping, phase unbalance percentage, digit selection
`timescale 1ns/100ps
`default_nettype none
`include "rlc_consts.vh"

module rlc_display (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Measured values, tenths of rated current
	input wire [9:0] phase_l1,
	input wire [9:0] phase_l2,
	input wire [9:0] phase_l3,
	input wire [9:0] residual,
	// Selection
	input wire [2:0] disp_sel,
	// Display
	output reg [9:0] disp_value_r,
	output reg [4:0] disp_indicator_r
);

	// ------------------------------------------------------------
	// Clamping and extremes
	// ------------------------------------------------------------
	wire [9:0] l1_c = (phase_l1 > `RLC_PHASE_MAX) ? `RLC_PHASE_MAX : phase_l1;
	wire [9:0] l2_c = (phase_l2 > `RLC_PHASE_MAX) ? `RLC_PHASE_MAX : phase_l2;
	wire [9:0] l3_c = (phase_l3 > `RLC_PHASE_MAX) ? `RLC_PHASE_MAX : phase_l3;
	wire [9:0] res_c = (residual > `RLC_RESID_MAX) ? `RLC_RESID_MAX : residual;
	wire [9:0] mx12 = (l1_c > l2_c) ? l1_c : l2_c;
	wire [9:0] mn12 = (l1_c < l2_c) ? l1_c : l2_c;
	wire [9:0] ph_max = (mx12 > l3_c) ? mx12 : l3_c;
	wire [9:0] ph_min = (mn12 < l3_c) ? mn12 : l3_c;

	// ------------------------------------------------------------
	// Serial divider: (max - min) * 100 / max
	// ------------------------------------------------------------
	// One bit per cycle keeps the area small; the percentage lags by 18 cycles
	reg [4:0] cnt_r;
	reg [16:0] num_r;
	reg [10:0] rem_r;
	reg [16:0] quo_r;
	reg [9:0] den_r;
	reg [9:0] pct_r;
	wire [10:0] rem_t = {rem_r[9:0], num_r[16]};
	wire fits = (rem_t >= {1'b0, den_r});
	wire [16:0] diff_x100 = {7'h00, ph_max - ph_min} * 17'h00064;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_r <= 5'h00;
			num_r <= 17'h00000;
			rem_r <= 11'h000;
			quo_r <= 17'h00000;
			den_r <= 10'h000;
			pct_r <= 10'h000;
		end
		else if (cnt_r == 5'h00)
		begin
			// Publish the finished quotient, then load a fresh sample
			if (den_r == 10'h000)
				pct_r <= 10'h000;
			else if (quo_r > {7'h00, `RLC_PCT_MAX})
				pct_r <= `RLC_PCT_MAX;
			else
				pct_r <= quo_r[9:0];
			num_r <= diff_x100;
			den_r <= ph_max;
			rem_r <= 11'h000;
			quo_r <= 17'h00000;
			cnt_r <= 5'h11;
		end
		else
		begin
			rem_r <= fits ? (rem_t - {1'b0, den_r}) : rem_t;
			quo_r <= {quo_r[15:0], fits};
			num_r <= {num_r[15:0], 1'b0};
			cnt_r <= cnt_r - 5'h01;
		end
	end

	// ------------------------------------------------------------
	// Digit value and quantity indicator
	// ------------------------------------------------------------
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			disp_value_r <= 10'h000;
			disp_indicator_r <= 5'h00;
		end
		else
		begin
			case (disp_sel)
				`RLC_DISP_L1:
				begin
					disp_value_r <= l1_c;
					disp_indicator_r <= 5'h01;
				end
				`RLC_DISP_L2:
				begin
					disp_value_r <= l2_c;
					disp_indicator_r <= 5'h02;
				end
				`RLC_DISP_L3:
				begin
					disp_value_r <= l3_c;
					disp_indicator_r <= 5'h04;
				end
				`RLC_DISP_RES:
				begin
					disp_value_r <= res_c;
					disp_indicator_r <= 5'h08;
				end
				`RLC_DISP_UNB:
				begin
					disp_value_r <= pct_r;
					disp_indicator_r <= 5'h10;
				end
				default:
				begin
					disp_value_r <= 10'h000;
					disp_indicator_r <= 5'h00;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// ### rlc_matrix.v
// Control input matrix, bank selection and output routing with AXI4-Lite registers
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "rlc_consts.vh"

module rlc_matrix (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// External control contacts
	input wire block_input_one,
	input wire block_input_two,
	input wire remote_reset_input,
	// Stage start and operate signals
	input wire [10:0] stage_signal,
	// Measured values, tenths of rated current
	input wire [9:0] phase_l1,
	input wire [9:0] phase_l2,
	input wire [9:0] phase_l3,
	input wire [9:0] residual,
	// Stage control
	output reg [4:0] stage_block_r,
	output reg bank_second_r,
	// Output relays
	output reg [3:0] start_output_r,
	output reg [3:0] trip_output_r,
	// Clearing strobes
	output reg indicator_clear_r,
	output reg latch_clear_r,
	output reg record_clear_r,
	// Display
	output wire [9:0] disp_value_r,
	output wire [4:0] disp_indicator_r,
	// Interrupt
	output reg irq_r
);

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	reg [7:0] swb_r [0:2];
	reg [7:0] swr_r [0:10];
	reg serial_bank_r;
	reg [3:0] irq_stat_r;
	reg [3:0] irq_mask_r;
	reg [2:0] disp_sel_r;
	reg [3:0] latch_en_r;
	reg [3:0] latched_r;
	reg [3:0] indic_r;
	reg [3:0] trip_prev_r;
	reg bank_prev_r;

	// Checksum as a sum of switch weights
	function [8:0] checksum;
		input [7:0] sw;
		integer i;
		begin
			checksum = 9'h000;
			for (i = 0; i < 8; i = i + 1)
				if (sw[i])
					checksum = checksum + (9'h001 << i);
		end
	endfunction

	// ------------------------------------------------------------
	// Control inputs
	// ------------------------------------------------------------
	wire [2:0] ctl_in = {remote_reset_input, block_input_two, block_input_one};
	wire [2:0] bank_en;
	wire [2:0] ind_req;
	wire [2:0] latch_req;
	wire [2:0] rec_req;
	wire [4:0] stage_blk [0:2];

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_ctl
			assign stage_blk[gi][3:0] = ctl_in[gi] ? swb_r[gi][3:0] : 4'h0;
			if (gi == 0)
			begin : g_first
				assign stage_blk[gi][`RLC_UNBAL_STAGE] = ctl_in[gi] & swb_r[gi][`RLC_SWB_BIT6];
				assign ind_req[gi] = 1'b0;
			end
			else
			begin : g_rest
				assign stage_blk[gi][`RLC_UNBAL_STAGE] = 1'b0;
				assign ind_req[gi] = ctl_in[gi] & swb_r[gi][`RLC_SWB_BIT6];
			end
			assign latch_req[gi] = ctl_in[gi] & swb_r[gi][`RLC_SWB_IND_LATCH];
			assign rec_req[gi] = ctl_in[gi] & swb_r[gi][`RLC_SWB_ALL];
			assign bank_en[gi] = swb_r[gi][`RLC_SWB_BANK];
		end
	endgenerate

	// Any enabled input blocks the stage
	wire [4:0] block_nxt = stage_blk[0] | stage_blk[1] | stage_blk[2];
	wire clr_ind = |ind_req | |latch_req | |rec_req;
	wire clr_latch = |latch_req | |rec_req;
	wire clr_rec = |rec_req;

	// A bank switch hands the choice over to the contact level alone
	wire bank_nxt = (|bank_en) ? |(bank_en & ctl_in) : serial_bank_r;

	// ------------------------------------------------------------
	// Output routing
	// ------------------------------------------------------------
	wire [3:0] start_nxt;
	wire [3:0] routed_trip;
	reg [3:0] start_acc;
	reg [3:0] trip_acc;
	integer si;

	always @*
	begin
		start_acc = 4'h0;
		trip_acc = 4'h0;
		for (si = 0; si < `RLC_NUM_SWR; si = si + 1)
		begin
			if (stage_signal[si])
			begin
				start_acc = start_acc | swr_r[si][3:0];
				trip_acc = trip_acc | swr_r[si][7:4];
			end
		end
	end

	assign start_nxt = start_acc;
	assign routed_trip = trip_acc;
	// Latched trips hold until a latch clear, so the breaker sees a firm command
	wire [3:0] latched_nxt = clr_latch ? 4'h0 : (latched_r | (routed_trip & latch_en_r));
	wire [3:0] trip_nxt = routed_trip | latched_nxt;

	// ------------------------------------------------------------
	// AXI4-Lite handshake
	// ------------------------------------------------------------
	reg aw_got_r;
	reg w_got_r;
	reg [7:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	wire do_write = aw_got_r && w_got_r && !s_axi_bvalid;
	wire wr_swr = (awaddr_r >= `RLC_ADDR_SWR_BASE) && (awaddr_r <= `RLC_ADDR_SWR_LAST) &&
		(awaddr_r[1:0] == 2'h0);
	wire [3:0] wr_swr_idx = awaddr_r[5:2];
	wire wr_map = wr_swr || (awaddr_r <= `RLC_ADDR_INDIC && awaddr_r[1:0] == 2'h0);
	wire wr_lo = do_write && wstrb_r[0];
	wire [3:0] irq_w1c = (wr_lo && awaddr_r == `RLC_ADDR_IRQ_STAT) ? wdata_r[3:0] : 4'h0;
	wire [3:0] ind_w1c = (wr_lo && awaddr_r == `RLC_ADDR_INDIC) ? wdata_r[3:0] : 4'h0;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RLC_RESP_OKAY;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end
		else
		begin
			s_axi_awready <= s_axi_awvalid && !aw_got_r && !s_axi_awready;
			s_axi_wready <= s_axi_wvalid && !w_got_r && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? `RLC_RESP_OKAY : `RLC_RESP_SLVERR;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	generate
		for (gi = 0; gi < `RLC_NUM_SWR; gi = gi + 1)
		begin : g_swr
			always @(posedge aclk)
			begin
				if (!aresetn)
					swr_r[gi] <= `RLC_RST_SW;
				else if (wr_lo && wr_swr && wr_swr_idx == gi)
					swr_r[gi] <= wdata_r[7:0];
			end
		end
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_swb
			always @(posedge aclk)
			begin
				if (!aresetn)
					swb_r[gi] <= `RLC_RST_SW;
				else if (wr_lo && awaddr_r == (`RLC_ADDR_SWB1 + 8'h04 * gi))
					swb_r[gi] <= wdata_r[7:0];
			end
		end
	endgenerate

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			serial_bank_r <= 1'b0;
			irq_mask_r <= 4'h0;
			disp_sel_r <= `RLC_RST_SEL;
			latch_en_r <= 4'h0;
		end
		else if (wr_lo)
		begin
			// Serial bank command only counts with the right code
			if (awaddr_r == `RLC_ADDR_BANK && wdata_r[7:0] == `RLC_BANK_CMD && wstrb_r[1])
				serial_bank_r <= wdata_r[`RLC_BANK_BIT];
			if (awaddr_r == `RLC_ADDR_IRQ_MASK)
				irq_mask_r <= wdata_r[3:0];
			if (awaddr_r == `RLC_ADDR_DISP_SEL)
				disp_sel_r <= wdata_r[2:0];
			if (awaddr_r == `RLC_ADDR_LATCH_EN)
				latch_en_r <= wdata_r[3:0];
		end
	end

	// ------------------------------------------------------------
	// Outputs, indicators and interrupts
	// ------------------------------------------------------------
	// Events: start rise, trip rise, bank change, clear by contact
	wire [3:0] irq_ev = {clr_ind, bank_nxt ^ bank_prev_r, |(trip_nxt & ~trip_prev_r),
		|(start_nxt & ~start_output_r)};

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stage_block_r <= 5'h00;
			bank_second_r <= 1'b0;
			bank_prev_r <= 1'b0;
			start_output_r <= 4'h0;
			trip_output_r <= 4'h0;
			trip_prev_r <= 4'h0;
			latched_r <= 4'h0;
			indic_r <= 4'h0;
			indicator_clear_r <= 1'b0;
			latch_clear_r <= 1'b0;
			record_clear_r <= 1'b0;
			irq_stat_r <= 4'h0;
			irq_r <= 1'b0;
		end
		else
		begin
			stage_block_r <= block_nxt;
			bank_second_r <= bank_nxt;
			bank_prev_r <= bank_nxt;
			start_output_r <= start_nxt;
			trip_output_r <= trip_nxt;
			trip_prev_r <= trip_nxt;
			latched_r <= latched_nxt;
			// A trip in the clearing cycle keeps its indicator lit
			indic_r <= ((clr_ind ? 4'h0 : indic_r) & ~ind_w1c) | trip_nxt;
			indicator_clear_r <= clr_ind;
			latch_clear_r <= clr_latch;
			record_clear_r <= clr_rec;
			irq_stat_r <= (irq_stat_r & ~irq_w1c) | irq_ev;
			irq_r <= |(((irq_stat_r & ~irq_w1c) | irq_ev) & irq_mask_r);
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	wire [3:0] rd_swr_idx = s_axi_araddr[5:2];
	reg [31:0] rd_data;
	reg rd_ok;

	always @*
	begin
		rd_data = 32'h00000000;
		rd_ok = 1'b1;
		if (s_axi_araddr[1:0] != 2'h0)
			rd_ok = 1'b0;
		else if (s_axi_araddr >= `RLC_ADDR_SWR_BASE && s_axi_araddr <= `RLC_ADDR_SWR_LAST)
			rd_data = {15'h0000, checksum(swr_r[rd_swr_idx]), swr_r[rd_swr_idx]};
		else
		begin
			case (s_axi_araddr)
				`RLC_ADDR_SWB1: rd_data = {15'h0000, checksum(swb_r[0]), swb_r[0]};
				`RLC_ADDR_SWB2: rd_data = {15'h0000, checksum(swb_r[1]), swb_r[1]};
				`RLC_ADDR_SWB3: rd_data = {15'h0000, checksum(swb_r[2]), swb_r[2]};
				`RLC_ADDR_BANK: rd_data = {23'h000000, serial_bank_r, 8'h00};
				`RLC_ADDR_STATUS: rd_data = {14'h0000, bank_second_r, stage_block_r,
					trip_output_r, start_output_r, 4'h0};
				`RLC_ADDR_IRQ_STAT: rd_data = {28'h0000000, irq_stat_r};
				`RLC_ADDR_IRQ_MASK: rd_data = {28'h0000000, irq_mask_r};
				`RLC_ADDR_DISP_SEL: rd_data = {29'h00000000, disp_sel_r};
				`RLC_ADDR_DISP_VAL: rd_data = {17'h00000, disp_indicator_r, disp_value_r};
				`RLC_ADDR_LATCH_EN: rd_data = {28'h0000000, latch_en_r};
				`RLC_ADDR_INDIC: rd_data = {28'h0000000, indic_r};
				default: rd_ok = 1'b0;
			endcase
		end
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RLC_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_ok ? `RLC_RESP_OKAY : `RLC_RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Display
	// ------------------------------------------------------------
	rlc_display u_display (
		.aclk(aclk),
		.aresetn(aresetn),
		.phase_l1(phase_l1),
		.phase_l2(phase_l2),
		.phase_l3(phase_l3),
		.residual(residual),
		.disp_sel(disp_sel_r),
		.disp_value_r(disp_value_r),
		.disp_indicator_r(disp_indicator_r)
	);

endmodule
`default_nettype wire

// ### rlc_matrix_properties.sv
// Port-level assertions for the relay control and routing matrix
`timescale 1ns/100ps
`default_nettype none
module rlc_matrix_properties (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// Field inputs
	input wire logic block_input_one,
	input wire logic block_input_two,
	input wire logic remote_reset_input,
	input wire logic [10:0] stage_signal,
	// Outputs
	input wire logic [4:0] stage_block_r,
	input wire logic [3:0] start_output_r,
	input wire logic indicator_clear_r,
	input wire logic latch_clear_r,
	input wire logic record_clear_r,
	input wire logic [9:0] disp_value_r,
	input wire logic [4:0] disp_indicator_r
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic any_contact;
	assign any_contact = block_input_one | block_input_two | remote_reset_input;
	// -----------------------------------------------
	// Bus answers
	// -----------------------------------------------
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_rd_take |=> s_axi_rvalid) else $error("read data late");
	// -----------------------------------------------
	// Contacts, routing and display
	// -----------------------------------------------
	// A clear or block with every contact open would drop a live stage
	a_block_cause: assert property (|stage_block_r |-> $past(any_contact))
		else $error("stage blocked without a contact");
	a_unbal_block: assert property (stage_block_r[4] |-> $past(block_input_one))
		else $error("unbalance stage blocked by wrong input");
	a_clear_cause: assert property (indicator_clear_r |-> $past(any_contact))
		else $error("indicator clear without contact");
	a_latch_clear: assert property (latch_clear_r |-> indicator_clear_r)
		else $error("latch clear without indicator clear");
	a_record_clear: assert property (record_clear_r |-> latch_clear_r && indicator_clear_r)
		else $error("record clear incomplete");
	a_start_cause: assert property (|start_output_r |-> $past(|stage_signal))
		else $error("start output without stage signal");
	a_disp_onehot: assert property ($onehot0(disp_indicator_r))
		else $error("display indicator not one-hot");
	a_phase_range: assert property ((|disp_indicator_r[2:0]) [*3] |-> disp_value_r <= 10'h276)
		else $error("phase value out of range");
	a_resid_range: assert property (disp_indicator_r[3] [*3] |-> disp_value_r <= 10'h0D2)
		else $error("residual value out of range");
	a_unbal_range: assert property (disp_indicator_r[4] [*3] |-> disp_value_r <= 10'h064)
		else $error("unbalance percent out of range");
endmodule
bind rlc_matrix rlc_matrix_properties u_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.block_input_one(block_input_one), .block_input_two(block_input_two),
	.remote_reset_input(remote_reset_input), .stage_signal(stage_signal),
	.stage_block_r(stage_block_r), .start_output_r(start_output_r),
	.indicator_clear_r(indicator_clear_r), .latch_clear_r(latch_clear_r),
	.record_clear_r(record_clear_r), .disp_value_r(disp_value_r),
	.disp_indicator_r(disp_indicator_r));
`default_nettype wire

// ### rlc_field.sv
// Field side model: control contacts, stage pickups and breaker trip coils
`timescale 1ns/100ps
`default_nettype none
module rlc_field (
	// Clock
	input wire logic aclk,
	// Requested field state
	input wire logic [2:0] want_contact,
	input wire logic [10:0] want_stage,
	// Toward the relay
	output logic block_input_one,
	output logic block_input_two,
	output logic remote_reset_input,
	output logic [10:0] stage_signal,
	// Breaker side
	input wire logic [3:0] trip_output_r,
	output int breaker_trips
);
	logic [3:0] trip_prev_r;
	initial
	begin
		{block_input_one, block_input_two, remote_reset_input} = 3'h0;
		stage_signal = 11'h000;
		trip_prev_r = 4'h0;
		breaker_trips = 0;
	end
	// Contacts change only after an edge; no bounce is modelled
	always @(posedge aclk)
	begin
		{remote_reset_input, block_input_two, block_input_one} <= want_contact;
		stage_signal <= want_stage;
		trip_prev_r <= trip_output_r;
		if ((trip_output_r & ~trip_prev_r) != 4'h0)
			breaker_trips <= breaker_trips + 1;
	end
endmodule
`default_nettype wire

// ### rlc_matrix_tb.sv
// Self-checking bench for the relay control and routing matrix
`timescale 1ns/100ps
`default_nettype none
`include "rlc_consts.vh"
module rlc_matrix_tb;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic [3:0] wstrb = 0, sto, tro;
	logic [1:0] bresp, rresp, rs;
	logic awready, wready, bvalid, arready, rvalid, bi1, bi2, rri, bank, icl, lcl, rcl, irq;
	logic [2:0] want_c = 0;
	logic [10:0] want_s = 0, stg;
	logic [9:0] ph [3] = '{0, 0, 0};
	logic [9:0] res = 0, dval;
	logic [4:0] blk, dind;
	int trips, n_mismatch = 0, tests_run = 0, swb [3], swr [11], sbank = 0, i, j, e;
	rlc_matrix uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.block_input_one(bi1), .block_input_two(bi2), .remote_reset_input(rri),
		.stage_signal(stg), .phase_l1(ph[0]), .phase_l2(ph[1]), .phase_l3(ph[2]),
		.residual(res), .stage_block_r(blk), .bank_second_r(bank), .start_output_r(sto),
		.trip_output_r(tro), .indicator_clear_r(icl), .latch_clear_r(lcl),
		.record_clear_r(rcl), .disp_value_r(dval), .disp_indicator_r(dind), .irq_r(irq));
	rlc_field field (.aclk(aclk), .want_contact(want_c), .want_stage(want_s),
		.block_input_one(bi1), .block_input_two(bi2), .remote_reset_input(rri),
		.stage_signal(stg), .trip_output_r(tro), .breaker_trips(trips));
	always #50 aclk = ~aclk;
	task report_and_stop;
		$display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask
	// -----------------------------------------------
	// Register bus master
	// -----------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		logic ah, wh, bh;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (ah)
				awvalid <= 1'b0;
			if (wh)
				wvalid <= 1'b0;
			if (bh)
				break;
		end
		bready <= 1'b0;
		chk("write answered", n < 50, 1);
		if (n == 50)
			report_and_stop();
	endtask
	task automatic rdr(input logic [7:0] a);
		int n;
		logic ah, bh;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			ah = arvalid & arready;
			bh = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ah)
				arvalid <= 1'b0;
			if (bh)
				break;
		end
		rready <= 1'b0;
		chk("read answered", n < 50, 1);
		if (n == 50)
			report_and_stop();
	endtask
	// -----------------------------------------------
	// Reference model
	// -----------------------------------------------
	function automatic logic [3:0] route(input logic [10:0] s, input int hi);
		logic [3:0] o = 0;
		for (int g = 0; g < 11; g++)
			if (s[g])
				o |= 4'(swr[g] >> hi);
		return o;
	endfunction
	function automatic logic [8:0] ctl(input logic [2:0] c);
		logic [4:0] b = 0;
		logic k = 0, ic = 0, lc = 0, rc = 0, bs = 0;
		for (int g = 0; g < 3; g++)
		begin
			bs |= swb[g][4];
			if (c[g])
			begin
				b[3:0] |= 4'(swb[g]);
				k |= swb[g][4];
				ic |= (g > 0 && swb[g][5]) || swb[g][6] || swb[g][7];
				lc |= swb[g][6] | swb[g][7];
				rc |= swb[g][7];
			end
		end
		b[4] = c[0] & swb[0][5];
		return {rc, lc, ic, bs ? k : sbank[0], b};
	endfunction
	function automatic int unb();
		// Unbalance is taken from the clamped phase values
		int mx = 0, mn = 630, v;
		for (int k = 0; k < 3; k++)
		begin
			v = ph[k] > 630 ? 630 : ph[k];
			if (v > mx)
				mx = v;
			if (v < mn)
				mn = v;
		end
		return mx == 0 ? 0 : (mx - mn) * 100 / mx;
	endfunction
	// -----------------------------------------------
	// Scenarios
	// -----------------------------------------------
	initial
	begin
		void'($urandom(11927));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(`RLC_ADDR_STATUS);
		chk("status after reset", rd, 0);
		rdr(8'h30);
		chk("unmapped resp", rs, `RLC_RESP_SLVERR);
		for (i = 0; i < 11; i++)
		begin
			swr[i] = $urandom % 256;
			wr(8'(`RLC_ADDR_SWR_BASE + 4 * i), swr[i], 4'h1);
			rdr(8'(`RLC_ADDR_SWR_BASE + 4 * i));
			chk("routing checksum", rd, swr[i] * 257);
		end
		for (i = 0; i < 20; i++)
		begin
			@(posedge aclk);
			want_s <= 11'($urandom);
			cyc(3);
			chk("start outputs", sto, route(stg, 0));
			chk("trip outputs", tro, route(stg, 4));
		end
		want_s <= 0;
		wr(`RLC_ADDR_BANK, 32'h196, 4'h3);
		sbank = 1;
		cyc(2);
		chk("serial bank", bank, 1);
		for (i = 0; i < 24; i++)
		begin
			// One switch set serves both banks, so both carry the same bank switch
			for (j = 0; j < 3; j++)
			begin
				swb[j] = $urandom % 256;
				wr(8'(4 * j), swb[j], 4'h1);
				rdr(8'(4 * j));
				chk("control checksum", rd, swb[j] * 257);
			end
			@(posedge aclk);
			want_c <= 3'($urandom);
			cyc(3);
			chk("contact outputs", {rcl, lcl, icl, bank, blk}, ctl(want_c));
		end
		want_c <= 0;
		for (i = 0; i < 4; i++)
		begin
			@(posedge aclk);
			for (j = 0; j < 3; j++)
				ph[j] <= 10'($urandom % (i[0] ? 1024 : 631));
			res <= 10'($urandom % 1024);
			for (j = 0; j < 6; j++)
			begin
				wr(`RLC_ADDR_DISP_SEL, j, 4'h1);
				cyc(40);
				e = j > 4 ? 0 : j == 4 ? unb() : j == 3 ? (res > 210 ? 210 : res)
					: (ph[j] > 630 ? 630 : ph[j]);
				chk("display value", dval, e);
				chk("display indicator", dind, j > 4 ? 0 : 1 << j);
			end
		end
		wr(`RLC_ADDR_SWR_BASE, 1, 4'h1);
		wr(`RLC_ADDR_IRQ_MASK, 0, 4'h1);
		wr(`RLC_ADDR_IRQ_STAT, 32'hF, 4'h1);
		cyc(2);
		chk("irq idle", irq, 0);
		@(posedge aclk);
		want_s <= 11'h001;
		cyc(4);
		chk("irq masked", irq, 0);
		rdr(`RLC_ADDR_IRQ_STAT);
		chk("irq status", rd[0], 1);
		wr(`RLC_ADDR_IRQ_MASK, 1, 4'h1);
		cyc(2);
		chk("irq raised", irq, 1);
		wr(`RLC_ADDR_IRQ_STAT, 1, 4'h1);
		cyc(2);
		chk("irq cleared", irq, 0);
		wr(`RLC_ADDR_LATCH_EN, 1, 4'h1);
		chk("write resp", rs, `RLC_RESP_OKAY);
		e = trips;
		wr(`RLC_ADDR_SWR_BASE, 32'h10, 4'h1);
		@(posedge aclk);
		want_s <= 0;
		cyc(3);
		chk("latched trip", tro, 1);
		chk("breaker trips", trips - e, 1);
		rdr(`RLC_ADDR_INDIC);
		chk("trip indicator", rd[0], 1);
		wr(`RLC_ADDR_SWB1, 32'h40, 4'h1);
		@(posedge aclk);
		want_c <= 3'h1;
		cyc(3);
		chk("latch cleared", tro, 0);
		rdr(`RLC_ADDR_INDIC);
		chk("indicators cleared", rd, 0);
		report_and_stop();
	end
endmodule
`default_nettype wire
